// ### src/mmg_pkg.sv
// guard constants and types
package mmg_pkg;
    localparam int VA_W = 24;

    typedef enum logic [2:0] {
        MD_BOOT = 3'h0,
        MD_TEST = 3'h1,
        MD_CTLS = 3'h2,
        MD_SYS  = 3'h3,
        MD_USER = 3'h4
    } mmg_mode_t;

    // physical map
    localparam logic [23:0] ROM_TOP   = 24'h040000;
    localparam logic [23:0] NVM_BASE  = 24'h100000;
    localparam logic [23:0] NVM_TOP   = 24'h120000;
    localparam logic [23:0] RAM_BASE  = 24'h200000;
    localparam logic [23:0] RAM_TOP   = 24'h202000;
    localparam logic [23:0] FUSE_SIZE = 24'h000080;
    localparam logic [23:0] FUSE_BASE = NVM_TOP - FUSE_SIZE;
    localparam logic [23:0] INIT_BASE = 24'h110000;
    localparam logic [23:0] INIT_TOP  = 24'h110080;
    // partition split points, standard and contactless configuration
    localparam logic [23:0] ROM_SPLIT_STD  = 24'h030000;
    localparam logic [23:0] ROM_SPLIT_CTLS = 24'h020000;
    localparam logic [23:0] NVM_SPLIT_STD  = FUSE_BASE;
    localparam logic [23:0] NVM_SPLIT_CTLS = 24'h118000;
    localparam logic [23:0] RAM_SPLIT_STD  = 24'h201800;
    localparam logic [23:0] RAM_SPLIT_CTLS = 24'h201000;
    // fuse row areas, byte offsets inside the row
    localparam logic [6:0] FR_RO_OFF = 7'h30;
    localparam logic [6:0] FR_WP_OFF = 7'h50;
    localparam logic [6:0] FR_WO_OFF = 7'h60;

    // register byte offsets
    localparam logic [11:0] REG_MODE      = 12'h000;
    localparam logic [11:0] REG_CTLS_RD   = 12'h008;
    localparam logic [11:0] REG_CTLS_WR   = 12'h00c;
    localparam logic [11:0] REG_EXC       = 12'h010;
    localparam logic [11:0] REG_EXC_ADDR  = 12'h014;
    localparam logic [11:0] REG_FUSE_LOCK = 12'h018;
    localparam int          SEG_BASE_BIT  = 11;

    // segment entry kinds
    localparam logic [1:0] SEG_USE  = 2'h0;
    localparam logic [1:0] SEG_SKIP = 2'h1;
    localparam logic [1:0] SEG_END  = 2'h2;
    localparam int         SEG_N    = 64;

    // exception cause bits
    localparam int EXC_RANGE = 0;
    localparam int EXC_PART  = 1;
    localparam int EXC_SEG   = 2;
    localparam int EXC_FUSE  = 3;

    localparam logic [1:0]  MS_NONE = 2'h0;
    localparam logic [1:0]  MS_ROM  = 2'h1;
    localparam logic [1:0]  MS_NVM  = 2'h2;
    localparam logic [1:0]  MS_RAM  = 2'h3;
    localparam logic [15:0] CTLS_RIGHTS_RST = 16'h0000;
    localparam logic [31:0] ALL_RIGHTS      = 32'hffffffff;

    typedef struct packed {
        logic [1:0]  kind;
        logic [2:0]  rwx;
        logic [23:0] vstart;
        logic [23:0] vend;
        logic [23:0] offs;
        logic [31:0] sfr;
    } mmg_seg_t;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [11:0] address;
        logic [31:0] writedata;
    } mmg_av_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } mmg_av_rsp_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic        fetch;
        logic [23:0] vaddr;
        logic [31:0] wdata;
    } mmg_cpu_req_t;

    typedef struct packed {
        logic        valid;
        logic [1:0]  mem_sel;
        logic [23:0] paddr;
        logic        fuse_hit;
        logic [31:0] rdata;
        logic        exc;
        logic [3:0]  cause;
    } mmg_cpu_rsp_t;

    typedef struct packed {
        logic boot_done;
        logic set_sys;
        logic set_super;
        logic clr_sys;
        logic clr_super;
    } mmg_mode_ev_t;

    typedef struct packed {
        mmg_mode_t mode;
        logic      super_system_flag;
        logic      system_flag;
    } mmg_mode_out_t;

    typedef struct packed {
        logic [15:0] wr;
        logic [15:0] rd;
    } mmg_rights_t;

    typedef struct packed {
        logic            ssf;
        logic            sf;
        mmg_mode_t       sub;
        logic            test_ok;
        logic            ctls_cfg;
        logic            wp_lock;
        logic [15:0]     ctls_rd;
        logic [15:0]     ctls_wr;
        logic [3:0]      exc_cause;
        logic [23:0]     exc_addr;
        logic [31:0]     code_rights;
        logic [31:0][31:0] fuse;
        logic            av_wait;
        logic [31:0]     av_rdata;
        mmg_cpu_rsp_t    rsp;
        mmg_mode_out_t   mout;
        mmg_rights_t     rights;
    } mmg_state_t;
endpackage

// ### src/mmg_mode_and_memory_guard.sv
// mode sequencing, fuse guard and mmu
//
// Functional notes
// RQ1: every reset starts in hidden boot submode
// RQ2: strap picks test submode, else system mode
// RQ3: boot may go to test or system mode, never back
// RQ4: delivered part never enters test submode
// RQ5: boot only right after reset
// RQ6: after start-up, super-system flag means contactless
// RQ7: software cannot alter fuse security configuration; test submode writes it freely
// RQ8: top 128 nonvolatile bytes are a guarded fuse row
// RQ9: 32-byte fuse area readable, writes rejected; test submode writes it freely
// RQ10: 16-byte fuse area writable until locked; test submode writes it after the lock too
// RQ11: 32-byte write-once area, ones never clear; test submode overwrites it, clearing ones
// RQ12: init data area unprotected, outside fuse row
// RQ13: every virtual address translated before memory
// RQ14: memories split in two; only test reaches both
// RQ15: partition fixed, set by contactless configuration
// RQ16: system mode defines segments, used in user mode
// RQ17: segment entry: rights, start, end, offset, group rights
// RQ18: relocation adds offset, partition still checked
// RQ19: up to 64 segments; skip and end codes
// RQ20: user code gets 16 group rights, reported only
// RQ21: privileged modes full rights; contactless locked registers
// RQ22: exception on forbidden user access or out of range
// RQ23: user mode when both flags clear
// RQ24: user access outside segments or forbidden type violates
`timescale 1ns/100ps
`default_nettype none
module mmg_mode_and_memory_guard
    import mmg_pkg::*;
(
    // clock and reset
    input  wire logic          clk,
    input  wire logic          rst,
    // production straps
    input  wire logic          test_strap,
    input  wire logic          delivered_strap,
    input  wire logic          ctls_cfg_strap,
    // register bus
    input  wire mmg_av_req_t   av_req,
    output var  mmg_av_rsp_t   av_rsp,
    // cpu side
    input  wire mmg_cpu_req_t  cpu_req,
    output var  mmg_cpu_rsp_t  cpu_rsp,
    input  wire mmg_mode_ev_t  mode_ev,
    output var  mmg_mode_out_t mode_out,
    output var  mmg_rights_t   rights
);

    mmg_state_t s_ff;
    mmg_state_t nxt_s;
    mmg_seg_t   seg_ff [SEG_N];
    logic       seg_we;
    logic [5:0] seg_idx;
    logic [2:0] seg_word;
    logic [31:0] seg_wd;

    function automatic mmg_mode_t mode_of(input logic ssf, input logic sf, input mmg_mode_t sub);
        if (ssf)
        begin
            return sub;
        end
        return sf ? MD_SYS : MD_USER; // [RQ23]
    endfunction

    mmg_mode_t   mode;
    logic        found;
    logic        stop;
    mmg_seg_t    ent;
    logic [23:0] pa;
    logic        in_rom;
    logic        in_nvm;
    logic        in_ram;
    logic        in_fuse;
    logic        v_range;
    logic        v_part;
    logic        v_seg;
    logic        v_fuse;
    logic [6:0]  fo;
    logic [4:0]  fidx;
    logic [3:0]  cause;
    logic        taken;
    logic [11:0] ad;
    logic [31:0] rd_mux;
    mmg_seg_t    seg_rd;

    always_comb
    begin
        nxt_s    = s_ff;
        mode     = mode_of(s_ff.ssf, s_ff.sf, s_ff.sub);
        found    = 1'b0;
        stop     = 1'b0;
        ent      = '0;
        seg_we   = 1'b0;
        seg_wd   = av_req.writedata;
        ad       = av_req.address;
        seg_idx  = ad[10:5];
        seg_word = ad[4:2];
        seg_rd   = seg_ff[ad[10:5]];
        rd_mux   = 32'h00000000;

        // mode sequencing
        if (s_ff.ssf && s_ff.sub == MD_BOOT)
        begin
            // straps frozen after boot
            nxt_s.test_ok  = test_strap & ~delivered_strap; // [RQ2] [RQ4]
            nxt_s.ctls_cfg = ctls_cfg_strap; // [RQ15]
            if (mode_ev.boot_done)
            begin
                if (s_ff.test_ok)
                begin
                    nxt_s.sub = MD_TEST; // [RQ2] [RQ3]
                end
                else
                begin
                    nxt_s.ssf = 1'b0; // [RQ2]
                    nxt_s.sf  = 1'b1;
                    nxt_s.sub = MD_CTLS; // [RQ5]
                end
            end
        end
        else
        begin
            if (mode_ev.clr_super)
            begin
                nxt_s.ssf = 1'b0;
                nxt_s.sub = MD_CTLS; // [RQ6]
                if (s_ff.ssf && s_ff.sub == MD_TEST)
                begin
                    nxt_s.sf = 1'b1;
                end
            end
            if (mode_ev.clr_sys)
            begin
                nxt_s.sf = 1'b0;
            end
            if (mode_ev.set_sys)
            begin
                nxt_s.sf = 1'b1;
            end
            if (mode_ev.set_super)
            begin
                // boot never re-entered
                nxt_s.ssf = 1'b1;
                nxt_s.sub = MD_CTLS; // [RQ3] [RQ5] [RQ6]
            end
        end

        // first match wins, end code stops
        for (int i = 0; i < SEG_N; i++)
        begin
            if (!stop)
            begin
                if (seg_ff[i].kind == SEG_END)
                begin
                    stop = 1'b1; // [RQ19]
                end
                else if (seg_ff[i].kind == SEG_USE && cpu_req.vaddr >= seg_ff[i].vstart
                         && cpu_req.vaddr <= seg_ff[i].vend)
                begin
                    found = 1'b1;
                    stop  = 1'b1;
                    ent   = seg_ff[i];
                end
            end
        end

        // translation: identity outside user mode
        if (mode == MD_USER)
        begin
            pa = 24'(cpu_req.vaddr + ent.offs); // [RQ13] [RQ16] [RQ18]
        end
        else
        begin
            pa = cpu_req.vaddr; // [RQ13]
        end

        in_rom  = pa < ROM_TOP;
        in_nvm  = pa >= NVM_BASE && pa < NVM_TOP;
        in_ram  = pa >= RAM_BASE && pa < RAM_TOP;
        in_fuse = pa >= FUSE_BASE && pa < NVM_TOP; // [RQ8]
        v_range = !(in_rom || in_nvm || in_ram); // [RQ22]

        // partition on relocated address
        v_part = 1'b0;
        if (mode != MD_TEST)
        begin
            if (in_rom)
            begin
                v_part = pa >= (s_ff.ctls_cfg ? ROM_SPLIT_CTLS : ROM_SPLIT_STD); // [RQ14] [RQ18]
            end
            if (in_nvm && !in_fuse)
            begin
                // init data area unguarded
                v_part = pa >= (s_ff.ctls_cfg ? NVM_SPLIT_CTLS : NVM_SPLIT_STD); // [RQ14] [RQ12]
            end
            if (in_ram)
            begin
                v_part = pa >= (s_ff.ctls_cfg ? RAM_SPLIT_CTLS : RAM_SPLIT_STD); // [RQ14]
            end
        end

        // segment rights in user mode only
        v_seg = 1'b0;
        if (mode == MD_USER)
        begin
            if (!found)
            begin
                v_seg = 1'b1; // [RQ24]
            end
            else if (cpu_req.fetch)
            begin
                v_seg = !ent.rwx[0]; // [RQ24]
            end
            else if (cpu_req.write)
            begin
                v_seg = !ent.rwx[1]; // [RQ24]
            end
            else
            begin
                v_seg = !ent.rwx[2]; // [RQ24]
            end
        end

        // fuse areas; test writes freely
        fo     = 7'(pa - FUSE_BASE);
        fidx   = fo[6:2];
        v_fuse = 1'b0;
        if (in_fuse && mode != MD_TEST)
        begin
            if (fo < FR_RO_OFF)
            begin
                v_fuse = 1'b1; // [RQ7] [RQ8]
            end
            else if (fo < FR_WP_OFF)
            begin
                v_fuse = cpu_req.write; // [RQ9]
            end
            else if (fo < FR_WO_OFF)
            begin
                v_fuse = cpu_req.write && s_ff.wp_lock; // [RQ10]
            end
        end

        cause = '0;
        cause[EXC_RANGE] = v_range;
        cause[EXC_PART]  = v_part;
        cause[EXC_SEG]   = v_seg;
        cause[EXC_FUSE]  = v_fuse;

        nxt_s.rsp.valid    = cpu_req.valid;
        nxt_s.rsp.paddr    = pa;
        nxt_s.rsp.fuse_hit = cpu_req.valid && in_fuse;
        nxt_s.rsp.rdata    = s_ff.fuse[fidx];
        nxt_s.rsp.exc      = cpu_req.valid && (cause != 4'h0); // [RQ22]
        nxt_s.rsp.cause    = cpu_req.valid ? cause : 4'h0;
        nxt_s.rsp.mem_sel  = MS_NONE;
        if (cpu_req.valid && cause == 4'h0 && !in_fuse)
        begin
            // blocked access reaches no memory
            nxt_s.rsp.mem_sel = in_rom ? MS_ROM : (in_nvm ? MS_NVM : MS_RAM);
        end
        if (cpu_req.valid && cause == 4'h0 && in_fuse && cpu_req.write)
        begin
            if (mode != MD_TEST && fo >= FR_WO_OFF)
            begin
                nxt_s.fuse[fidx] = s_ff.fuse[fidx] | cpu_req.wdata; // [RQ11]
            end
            else
            begin
                nxt_s.fuse[fidx] = cpu_req.wdata; // [RQ10]
            end
        end
        if (cpu_req.valid && mode == MD_USER && cpu_req.fetch && found)
        begin
            nxt_s.code_rights = ent.sfr; // [RQ17] [RQ20]
        end
        if (cpu_req.valid && cause != 4'h0)
        begin
            nxt_s.exc_addr = cpu_req.vaddr;
        end

        // one wait cycle; write lands with waitrequest low
        taken = 1'b0;
        if ((av_req.read || av_req.write) && s_ff.av_wait)
        begin
            nxt_s.av_wait = 1'b0;
            case (ad)
                REG_MODE:      rd_mux = {24'h0, s_ff.test_ok, s_ff.ctls_cfg, s_ff.ssf, s_ff.sf, 1'b0, mode};
                REG_CTLS_RD:   rd_mux = {16'h0, s_ff.ctls_rd};
                REG_CTLS_WR:   rd_mux = {16'h0, s_ff.ctls_wr};
                REG_EXC:       rd_mux = {28'h0, s_ff.exc_cause};
                REG_EXC_ADDR:  rd_mux = {8'h0, s_ff.exc_addr};
                REG_FUSE_LOCK: rd_mux = {31'h0, s_ff.wp_lock};
                default:       rd_mux = 32'h00000000;
            endcase
            if (ad[SEG_BASE_BIT])
            begin
                case (ad[4:2])
                    3'h0:    rd_mux = {27'h0, seg_rd.kind, seg_rd.rwx};
                    3'h1:    rd_mux = {8'h0, seg_rd.vstart};
                    3'h2:    rd_mux = {8'h0, seg_rd.vend};
                    3'h3:    rd_mux = {8'h0, seg_rd.offs};
                    3'h4:    rd_mux = seg_rd.sfr;
                    default: rd_mux = 32'h00000000;
                endcase
            end
            nxt_s.av_rdata = av_req.read ? rd_mux : 32'h00000000;
        end
        else if (!s_ff.av_wait)
        begin
            nxt_s.av_wait = 1'b1;
            taken = av_req.write;
        end

        if (taken)
        begin
            // contactless rights locked while that submode or user runs
            if (ad == REG_CTLS_RD && mode != MD_CTLS && mode != MD_USER)
            begin
                nxt_s.ctls_rd = av_req.writedata[15:0]; // [RQ21]
            end
            if (ad == REG_CTLS_WR && mode != MD_CTLS && mode != MD_USER)
            begin
                nxt_s.ctls_wr = av_req.writedata[15:0]; // [RQ21]
            end
            if (ad == REG_EXC)
            begin
                nxt_s.exc_cause = s_ff.exc_cause & ~av_req.writedata[3:0];
            end
            if (ad == REG_FUSE_LOCK && av_req.writedata[0])
            begin
                nxt_s.wp_lock = 1'b1; // [RQ10]
            end
            // table edits only from system or test code
            seg_we = ad[SEG_BASE_BIT] && (mode == MD_SYS || mode == MD_TEST); // [RQ16] [RQ17]
        end
        // a new cause in the clearing cycle is kept
        if (cpu_req.valid)
        begin
            nxt_s.exc_cause = nxt_s.exc_cause | cause;
        end

        // register group rights, reported only
        case (mode_of(nxt_s.ssf, nxt_s.sf, nxt_s.sub))
            MD_USER: nxt_s.rights = nxt_s.code_rights; // [RQ20]
            MD_CTLS: nxt_s.rights = {nxt_s.ctls_wr, nxt_s.ctls_rd}; // [RQ21]
            default: nxt_s.rights = ALL_RIGHTS; // [RQ21]
        endcase
        nxt_s.mout.mode              = mode_of(nxt_s.ssf, nxt_s.sf, nxt_s.sub);
        nxt_s.mout.super_system_flag = nxt_s.ssf;
        nxt_s.mout.system_flag       = nxt_s.sf;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_ff         <= '0;
            s_ff.ssf     <= 1'b1; // [RQ1]
            s_ff.sub     <= MD_BOOT; // [RQ1] [RQ5]
            s_ff.ctls_rd <= CTLS_RIGHTS_RST;
            s_ff.ctls_wr <= CTLS_RIGHTS_RST;
            s_ff.av_wait <= 1'b1;
            s_ff.rights  <= ALL_RIGHTS;
            s_ff.mout    <= '{MD_BOOT, 1'b1, 1'b0};
        end
        else
        begin
            s_ff <= nxt_s;
        end
    end

    // every entry resets to end of table
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < SEG_N; i++)
            begin
                seg_ff[i]      <= '0;
                seg_ff[i].kind <= SEG_END;
            end
        end
        else if (seg_we)
        begin
            case (seg_word)
                3'h0:    {seg_ff[seg_idx].kind, seg_ff[seg_idx].rwx} <= seg_wd[4:0];
                3'h1:    seg_ff[seg_idx].vstart <= seg_wd[23:0];
                3'h2:    seg_ff[seg_idx].vend <= seg_wd[23:0];
                3'h3:    seg_ff[seg_idx].offs <= seg_wd[23:0];
                3'h4:    seg_ff[seg_idx].sfr <= seg_wd;
                default: seg_ff[seg_idx].sfr <= seg_ff[seg_idx].sfr;
            endcase
        end
    end

    assign av_rsp   = '{s_ff.av_rdata, s_ff.av_wait};
    assign cpu_rsp  = s_ff.rsp;
    assign mode_out = s_ff.mout;
    assign rights   = s_ff.rights;

endmodule // mmg_mode_and_memory_guard
`default_nettype wire

// ### verif/mmg_sva.sv
// guard assertions
`timescale 1ns/100ps
`default_nettype none
module mmg_sva
    import mmg_pkg::*;
(
    // clock and reset
    input wire logic          clk,
    input wire logic          rst,
    // straps
    input wire logic          test_strap,
    input wire logic          delivered_strap,
    input wire logic          ctls_cfg_strap,
    // buses
    input wire mmg_av_req_t   av_req,
    input wire mmg_av_rsp_t   av_rsp,
    input wire mmg_cpu_req_t  cpu_req,
    input wire mmg_cpu_rsp_t  cpu_rsp,
    input wire mmg_mode_ev_t  mode_ev,
    input wire mmg_mode_out_t mode_out,
    input wire mmg_rights_t   rights
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    mmg_mode_t md;
    logic      bd;
    assign md = mode_out.mode;
    assign bd = mode_ev.boot_done && md == MD_BOOT;

    AST_RST_BOOT: assert property ($fell(rst) |-> md == MD_BOOT && mode_out.super_system_flag)
        else $error("no boot");
    AST_BOOT_TEST: assert property (bd && test_strap && !delivered_strap |=> md == MD_TEST)
        else $error("no test");
    AST_BOOT_SYS: assert property (bd && (!test_strap || delivered_strap) |=> md == MD_SYS)
        else $error("no system");
    AST_NO_REBOOT: assert property (md != MD_BOOT |=> md != MD_BOOT)
        else $error("reboot");
    AST_SSF_CTLS: assert property (mode_out.super_system_flag && !(md inside {MD_BOOT, MD_TEST}) |-> md == MD_CTLS)
        else $error("super flag");
    AST_USER_FLAGS: assert property (!mode_out.super_system_flag && !mode_out.system_flag |-> md == MD_USER)
        else $error("not user");
    AST_FULL_RIGHTS: assert property ((md inside {MD_BOOT, MD_TEST, MD_SYS})[*2] |-> rights == ALL_RIGHTS)
        else $error("rights");
    AST_RSP_ONE: assert property (1'b1 |=> cpu_rsp.valid == $past(cpu_req.valid))
        else $error("late response");
    AST_RANGE: assert property (cpu_req.valid && md != MD_USER && cpu_req.vaddr >= RAM_TOP
        |=> cpu_rsp.exc && cpu_rsp.cause[EXC_RANGE] && cpu_rsp.mem_sel == MS_NONE)
        else $error("range");
    AST_PART_SYS: assert property (cpu_req.valid && md == MD_SYS && !ctls_cfg_strap
        && cpu_req.vaddr inside {[ROM_SPLIT_STD:ROM_TOP - 1]} |=> cpu_rsp.exc && cpu_rsp.cause[EXC_PART])
        else $error("partition");
    AST_TEST_BOTH: assert property (cpu_req.valid && md == MD_TEST && cpu_req.vaddr inside {[ROM_SPLIT_STD:ROM_TOP - 1]}
        |=> !cpu_rsp.exc && cpu_rsp.mem_sel == MS_ROM)
        else $error("test blocked");
    AST_AV_WAIT: assert property ($rose(av_req.read || av_req.write) |=> !av_rsp.waitrequest ##1 av_rsp.waitrequest)
        else $error("bus wait");

    cover property (md == MD_TEST);
    cover property (md == MD_USER && cpu_rsp.valid);
    cover property (cpu_rsp.exc && cpu_rsp.cause[EXC_SEG]);
endmodule // mmg_sva
bind mmg_mode_and_memory_guard mmg_sva i_mmg_sva (.clk(clk), .rst(rst), .test_strap(test_strap),
    .delivered_strap(delivered_strap), .ctls_cfg_strap(ctls_cfg_strap), .av_req(av_req), .av_rsp(av_rsp),
    .cpu_req(cpu_req), .cpu_rsp(cpu_rsp), .mode_ev(mode_ev), .mode_out(mode_out), .rights(rights));
`default_nettype wire

// ### verif/mmg_cpu_model.sv
// cpu core model
`timescale 1ns/100ps
`default_nettype none
module mmg_cpu_model
    import mmg_pkg::*;
(
    // clock
    input  wire logic         clk,
    // towards the guard
    output var  mmg_cpu_req_t cpu_req,
    output var  mmg_mode_ev_t mode_ev
);
    initial
    begin
        cpu_req = '0;
        mode_ev = '0;
    end
    // virtual addresses only
    task automatic access(input logic w, input logic f, input logic [23:0] va, input logic [31:0] wd);
        @(posedge clk);
        cpu_req <= '{valid: 1'b1, write: w, fetch: f, vaddr: va, wdata: wd};
        @(posedge clk);
        // flip released lines
        cpu_req <= '{valid: 1'b0, write: ~w, fetch: ~f, vaddr: ~va, wdata: ~wd};
    endtask
    task automatic pulse(input mmg_mode_ev_t e);
        @(posedge clk);
        mode_ev <= e;
        @(posedge clk);
        mode_ev <= '0;
    endtask
endmodule // mmg_cpu_model
`default_nettype wire

// ### verif/mmg_mode_and_memory_guard_tb.sv
// guard bench
`timescale 1ns/100ps
`default_nettype none
module mmg_mode_and_memory_guard_tb
    import mmg_pkg::*;
;
    typedef struct {
        logic [3:0]  cm;
        logic [1:0]  sel;
        logic [23:0] pa;
        logic [31:0] rd;
        logic [2:0]  ck;
    } mmg_exp_t;
    logic          clk;
    logic          rst;
    logic          test_strap;
    logic          delivered_strap;
    logic          ctls_cfg_strap;
    mmg_av_req_t   av_req;
    mmg_av_rsp_t   av_rsp;
    mmg_cpu_req_t  cpu_req;
    mmg_cpu_rsp_t  cpu_rsp;
    mmg_mode_ev_t  mode_ev;
    mmg_mode_out_t mode_out;
    mmg_rights_t   rights;
    int            mismatches;
    int            checks;
    mmg_exp_t      q[$];
    mmg_exp_t      e;
    logic [31:0]   rdv;
    logic [23:0]   pofs;
    logic [23:0]   va;
    logic [31:0]   seg[10];

    mmg_mode_and_memory_guard i_mmg_mode_and_memory_guard (.clk(clk), .rst(rst), .test_strap(test_strap),
        .delivered_strap(delivered_strap), .ctls_cfg_strap(ctls_cfg_strap), .av_req(av_req), .av_rsp(av_rsp),
        .cpu_req(cpu_req), .cpu_rsp(cpu_rsp), .mode_ev(mode_ev), .mode_out(mode_out), .rights(rights));
    mmg_cpu_model i_mmg_cpu_model (.clk(clk), .cpu_req(cpu_req), .mode_ev(mode_ev));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
        checks++;
        if (s !== x)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // hold until waitrequest low
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        av_req <= '{read: !w, write: w, address: a, writedata: d};
        do
        begin
            @(posedge clk);
            n++;
        end
        while (av_rsp.waitrequest && n < 20);
        if (av_rsp.waitrequest)
            chk("bus timeout", 32'h1, 32'h0);
        rdv = av_rsp.readdata;
        av_req.read <= 1'b0;
        av_req.write <= 1'b0;
    endtask
    // ck: paddr, rdata, exc+sel
    task automatic acc(input logic w, input logic f, input logic [23:0] a, input logic [31:0] wd,
                       input logic [3:0] cm, input logic [1:0] sel, input logic [31:0] rd, input logic [2:0] ck);
        q.push_back('{cm, sel, a + pofs, rd, ck});
        i_mmg_cpu_model.access(w, f, a, wd);
    endtask
    task automatic ev(input mmg_mode_ev_t m, input mmg_mode_t x);
        i_mmg_cpu_model.pulse(m);
        @(posedge clk);
        chk("mode", mode_out.mode, x);
    endtask
    task automatic reset(input logic t, input logic d);
        rst <= 1'b1;
        test_strap <= t;
        delivered_strap <= d;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        chk("boot", mode_out.mode, MD_BOOT);
        chk("boot rights", rights, ALL_RIGHTS);
    endtask

    always @(posedge clk)
    begin
        if (cpu_rsp.valid === 1'b1)
        begin
            e = q.pop_front();
            if (e.ck[2])
            begin
                chk("exc", cpu_rsp.exc, |e.cm);
                chk("cause", cpu_rsp.cause & e.cm, e.cm);
                chk("sel", cpu_rsp.mem_sel, e.sel);
            end
            if (e.ck[0])
                chk("paddr", cpu_rsp.paddr, e.pa);
            if (e.ck[1])
                chk("rdata", cpu_rsp.rdata, e.rd);
        end
    end

    initial
    begin
        rst = 1'b1;
        test_strap = 1'b1;
        delivered_strap = 1'b0;
        ctls_cfg_strap = 1'b0;
        av_req = '0;
        mismatches = 0;
        checks = 0;
        pofs = '0;
        seg = '{32'h5, 32'h1000, 32'h1fff, 32'h100000, 32'hf00ff, 32'h7, 32'h2000, 32'h2fff, 32'h2e000, 32'h0};
        void'($urandom(21));
        reset(1'b1, 1'b0);
        ev(5'h10, MD_TEST);
        bus(0, REG_MODE, 0);
        chk("mode reg", rdv, 32'ha1);
        acc(0, 0, 24'h038000, 0, 0, MS_ROM, 0, 3'h5);
        acc(1, 0, 24'h11ffe0, 32'ha5, 0, MS_NONE, 0, 3'h6);
        acc(1, 0, 24'h11ffb0, 32'h77, 0, MS_NONE, 0, 3'h4);
        ev(5'h01, MD_SYS);
        ev(5'h10, MD_SYS);
        $display("test done");
        acc(0, 0, 24'h038000, 0, 4'h2, MS_NONE, 0, 3'h4);
        acc(0, 0, 24'h300000, 0, 4'h1, MS_NONE, 0, 3'h4);
        bus(0, REG_EXC_ADDR, 0);
        chk("fault addr", rdv, 32'h300000);
        acc(1, 0, 24'h110000, 1, 0, MS_NVM, 0, 3'h5);
        acc(1, 0, 24'h11ffe0, 32'h5a, 0, MS_NONE, 32'ha5, 3'h6);
        acc(1, 0, 24'h11ffe0, 0, 0, MS_NONE, 32'hff, 3'h2);
        acc(0, 0, 24'h11ffe0, 0, 0, MS_NONE, 32'hff, 3'h6);
        acc(1, 0, 24'h11ffb0, 32'h11, 4'h8, MS_NONE, 0, 3'h4);
        acc(0, 0, 24'h11ffb0, 0, 0, MS_NONE, 32'h77, 3'h6);
        acc(1, 0, 24'h11ffd0, 32'h1234, 0, MS_NONE, 0, 3'h4);
        bus(1, REG_FUSE_LOCK, 1);
        acc(1, 0, 24'h11ffd0, 32'h9999, 0, MS_NONE, 32'h1234, 3'h2);
        acc(0, 0, 24'h11ffd0, 0, 0, MS_NONE, 32'h1234, 3'h6);
        repeat (16)
        begin
            va = RAM_BASE + 24'($urandom % 32'h1800);
            acc(1'($urandom), 0, va, $urandom, 0, MS_RAM, 0, 3'h5);
        end
        bus(1, 12'h7fc, 32'hffff);
        bus(0, 12'h7fc, 0);
        chk("unmapped", rdv, 32'h0);
        bus(1, REG_CTLS_RD, 32'ha5);
        bus(1, REG_CTLS_WR, 32'h3);
        for (int i = 0; i < 10; i++)
            bus(1, 12'h800 + 12'(i / 5 * 32 + i % 5 * 4), seg[i]);
        chk("sys rights", rights, ALL_RIGHTS);
        ev(5'h02, MD_USER);
        $display("system done");
        pofs = 24'h100000;
        acc(0, 1, 24'h001000, 0, 0, MS_NVM, 0, 3'h5);
        acc(0, 0, 24'h001010, 0, 0, MS_NVM, 0, 3'h5);
        chk("user rights", rights, 32'h000f00ff);
        acc(1, 0, 24'h001010, 1, 4'h4, MS_NONE, 0, 3'h4);
        acc(0, 0, 24'h005000, 0, 4'h4, MS_NONE, 0, 3'h4);
        acc(0, 0, 24'h002000, 0, 4'h2, MS_NONE, 0, 3'h4);
        ev(5'h04, MD_CTLS);
        @(posedge clk);
        chk("ctls rights", rights, 32'h000300a5);
        bus(1, REG_CTLS_RD, 32'hffff);
        bus(0, REG_CTLS_RD, 0);
        chk("ctls locked", rdv, 32'ha5);
        $display("user done");
        ctls_cfg_strap <= 1'b1;
        reset(1'b1, 1'b1);
        ev(5'h10, MD_SYS);
        acc(0, 0, 24'h028000, 0, 4'h2, MS_NONE, 0, 3'h4);
        ev(5'h04, MD_CTLS);
        $display("delivered done");
        results();
    end
endmodule // mmg_mode_and_memory_guard_tb
`default_nettype wire
